// ---- logic/es_exception_sequencer.sv ----
// Exception sequencer: ranking, stacking, masking and vector fetch for the core
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module es_exception_sequencer
    import es_pkg::*;
(
    input wire logic CLK_I, // System clock, 250 MHz
    input wire logic RST_N_I, // Chip reset, active low, synchronous
    input wire logic WDT_OVF_I, // Watchdog overflow pulse
    input wire logic HSEL_I, // AHB-Lite slave select
    input wire logic [31:0] HADDR_I, // AHB-Lite address
    input wire logic [1:0] HTRANS_I, // AHB-Lite transfer type
    input wire logic HWRITE_I, // AHB-Lite write
    input wire logic [2:0] HSIZE_I, // AHB-Lite size
    input wire logic HREADY_I, // AHB-Lite bus ready
    input wire logic [31:0] HWDATA_I, // AHB-Lite write data
    output logic [31:0] HRDATA_O, // AHB-Lite read data
    output logic HREADYOUT_O, // AHB-Lite slave ready
    output logic HRESP_O, // AHB-Lite response, always OKAY
    input wire logic NMI_REQ_I, // Nonmaskable request level
    input wire logic [5:0] EXT_REQ_I, // External request lines 0 to 5
    input wire logic [26:0] INT_REQ_I, // Internal peripheral requests
    input wire logic INSN_DONE_I, // Core finished an instruction
    input wire logic TRAP_I, // Finished instruction was a trap
    input wire logic [1:0] TRAP_SEL_I, // Trap vector selector
    input wire logic [23:0] CORE_PC_I, // Return address to stack
    input wire logic [7:0] CORE_CCR_I, // Current condition flags
    input wire logic STK_ACK_I, // Stack push done
    input wire logic VEC_ACK_I, // Vector read done
    input wire logic [23:0] VEC_DATA_I, // Vector contents
    output es_push_s STK_O, // Stack push request with data
    output es_fetch_s VEC_O, // Vector read request with address
    output logic CCR_WR_O, // Write pulse for the condition flags
    output logic [7:0] CCR_O, // New condition flags value
    output logic JUMP_O, // Jump pulse for the core
    output logic [23:0] JUMP_PC_O, // Handler start address
    output logic CORE_HALT_O, // Core must stall
    output logic CHIP_RST_O, // Initialize peripherals
    output logic IRQ_ACK_O, // Interrupt accepted pulse
    output logic [5:0] ACK_VEC_O // Accepted interrupt vector
);

    typedef enum logic [2:0] {
        S_INIT,
        S_RUN,
        S_PUSH,
        S_MASK,
        S_FETCH,
        S_JUMP
    } es_state_e;

    es_state_e state_q;
    es_kind_e kind_q;
    es_ctrl_s ctrl_q;
    logic [5:0] vec_q;
    logic [5:0] last_vec_q;
    logic first_q;
    logic after_q;
    logic trap_pend_q;
    logic [1:0] trap_sel_q;
    logic [23:0] new_pc_q;

    logic rst_all;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic rd_go;
    logic wr_go;

    logic [ES_N_VEC-1:0] req_vec;
    logic [ES_N_VEC-1:0] lvl_vec;
    logic [ES_N_VEC-1:0] elig_vec;
    logic [11:0] prio_bits;
    logic mask_i;
    logic mask_ui;
    logic pick_ok;
    logic [5:0] pick_vec;
    logic eval;
    logic int_take;
    logic trap_take;
    logic [5:0] trap_vec;
    logic [15:0] vec_addr;
    logic [7:0] ccr_new;

    // Watchdog overflow resets the sequencer and control registers like the pin; the AHB-Lite handshake and read data flops reset on the pin only
    assign rst_all = !RST_N_I || WDT_OVF_I;

    // ---------------- AHB-Lite slave ----------------
    assign rd_go = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
    assign wr_go = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_go;
            wr_addr_q <= HADDR_I[7:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (rst_all) begin
            ctrl_q.adv_mode <= ES_ADV_RST;
            ctrl_q.user_bit_select <= ES_UBS_RST;
            ctrl_q.priority_select_a <= ES_PRIO_RST;
            ctrl_q.priority_select_b <= ES_PRIO_RST;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                ES_OFS_CTRL: begin
                    ctrl_q.adv_mode <= HWDATA_I[ES_CTRL_ADV_BIT];
                    ctrl_q.user_bit_select <= HWDATA_I[ES_CTRL_UBS_BIT];
                end
                ES_OFS_PRIO: begin
                    ctrl_q.priority_select_a <= HWDATA_I[7:0];
                    ctrl_q.priority_select_b <= HWDATA_I[15:8];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data is latched in the address phase so it stands in the data phase
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (rd_go) begin
            case (HADDR_I[7:0])
                ES_OFS_CTRL: begin
                    HRDATA_O <= {30'h0000_0000, ctrl_q.user_bit_select, ctrl_q.adv_mode};
                end
                ES_OFS_PRIO: begin
                    HRDATA_O <= {16'h0000, ctrl_q.priority_select_b, ctrl_q.priority_select_a};
                end
                ES_OFS_STAT: begin
                    HRDATA_O <= {21'h00_0000, trap_pend_q, first_q, (state_q != S_RUN), 2'h0, last_vec_q};
                end
                default: begin
                    HRDATA_O <= 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            HREADYOUT_O <= 1'b0;
            HRESP_O <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

    // ---------------- Interrupt ranking ----------------
    // Level bits: ext 0,1 own bits; ext 2/3 and 4/5 share; internals by group of four
    assign prio_bits = {ctrl_q.priority_select_b, ctrl_q.priority_select_a[3:0]};
    assign mask_i = CORE_CCR_I[ES_CCR_MASK_BIT];
    assign mask_ui = CORE_CCR_I[ES_CCR_AUX_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < ES_N_VEC; gi++) begin : g_vec
            if (gi >= 12 && gi < 12 + ES_N_EXT) begin : g_ext
                localparam int E = gi - 12;
                localparam int PB = (E < 2) ? (7 - E) : (E < 4 ? 5 : 4);
                assign req_vec[gi] = EXT_REQ_I[E];
                assign lvl_vec[gi] = ctrl_q.priority_select_a[PB];
            end else if (gi >= 20 && gi < 20 + ES_N_INT) begin : g_int
                localparam int K = gi - 20;
                assign req_vec[gi] = INT_REQ_I[K];
                assign lvl_vec[gi] = prio_bits[11 - K / 4];
            end else begin : g_none
                assign req_vec[gi] = 1'b0;
                assign lvl_vec[gi] = 1'b0;
            end
            // Mask: UE=1 I masks all; UE=0 I lets level 1 pass unless UI set
            assign elig_vec[gi] = req_vec[gi] && (!mask_i ||
                (!ctrl_q.user_bit_select && !mask_ui && lvl_vec[gi]));
        end
    endgenerate

    // Level 1 first, then level 0; lowest vector wins inside a level
    always_comb begin
        pick_ok = 1'b0;
        pick_vec = 6'h00;
        for (int i = ES_N_VEC - 1; i >= 0; i--) begin
            if (elig_vec[i] && !lvl_vec[i]) begin
                pick_ok = 1'b1;
                pick_vec = 6'(i);
            end
        end
        for (int i = ES_N_VEC - 1; i >= 0; i--) begin
            if (elig_vec[i] && lvl_vec[i]) begin
                pick_ok = 1'b1;
                pick_vec = 6'(i);
            end
        end
        if (NMI_REQ_I) begin
            pick_ok = 1'b1;
            pick_vec = ES_VEC_NMI;
        end
    end

    // Decisions only at instruction or sequence completion
    assign eval = (state_q == S_RUN) && (INSN_DONE_I || after_q);
    assign int_take = eval && !first_q && pick_ok;
    assign trap_take = eval && !int_take && (TRAP_I || trap_pend_q);
    assign trap_vec = ES_VEC_TRAP + {4'h0, (trap_pend_q ? trap_sel_q : TRAP_SEL_I)};

    // ---------------- Address and flag values ----------------
    assign vec_addr = ctrl_q.adv_mode ? {8'h00, vec_q, 2'b00} : {9'h000, vec_q, 1'b0};

    always_comb begin
        ccr_new = CORE_CCR_I;
        ccr_new[ES_CCR_MASK_BIT] = 1'b1;
        if (kind_q != EK_RESET && !ctrl_q.user_bit_select) begin
            ccr_new[ES_CCR_AUX_BIT] = 1'b1;
        end
    end

    // ---------------- Sequencer ----------------
    always_ff @(posedge CLK_I) begin
        if (rst_all) begin
            state_q <= S_INIT;
            kind_q <= EK_RESET;
            vec_q <= ES_VEC_RESET;
        end else begin
            case (state_q)
                S_INIT: begin
                    state_q <= S_MASK;
                end
                S_RUN: begin
                    if (int_take) begin
                        kind_q <= EK_IRQ;
                        vec_q <= pick_vec;
                        state_q <= S_PUSH;
                    end else if (trap_take) begin
                        kind_q <= EK_TRAP;
                        vec_q <= trap_vec;
                        state_q <= S_PUSH;
                    end
                end
                S_PUSH: begin
                    if (STK_ACK_I) begin
                        state_q <= S_MASK;
                    end
                end
                S_MASK: begin
                    state_q <= S_FETCH;
                end
                S_FETCH: begin
                    if (VEC_ACK_I) begin
                        state_q <= S_JUMP;
                    end
                end
                S_JUMP: begin
                    state_q <= S_RUN;
                end
                default: begin
                    state_q <= S_INIT;
                end
            endcase
        end
    end

    // Core-facing request outputs
    always_ff @(posedge CLK_I) begin
        if (rst_all) begin
            STK_O <= '0;
            VEC_O <= '0;
            CCR_WR_O <= 1'b0;
            CCR_O <= 8'h00;
            JUMP_O <= 1'b0;
            JUMP_PC_O <= 24'h00_0000;
            new_pc_q <= 24'h00_0000;
        end else begin
            CCR_WR_O <= 1'b0;
            JUMP_O <= 1'b0;
            if (state_q == S_RUN && (int_take || trap_take)) begin
                STK_O.req <= 1'b1;
                STK_O.data <= {CORE_CCR_I, CORE_PC_I};
            end else if (state_q == S_PUSH && STK_ACK_I) begin
                STK_O.req <= 1'b0;
            end
            if (state_q == S_MASK) begin
                CCR_WR_O <= 1'b1;
                CCR_O <= ccr_new;
                VEC_O.req <= 1'b1;
                VEC_O.addr <= vec_addr;
            end else if (state_q == S_FETCH && VEC_ACK_I) begin
                VEC_O.req <= 1'b0;
                new_pc_q <= ctrl_q.adv_mode ? VEC_DATA_I : {8'h00, VEC_DATA_I[15:0]};
            end
            if (state_q == S_JUMP) begin
                JUMP_O <= 1'b1;
                JUMP_PC_O <= new_pc_q;
            end
        end
    end

    // Completion flags: first-instruction block, re-evaluation, pending trap
    always_ff @(posedge CLK_I) begin
        if (rst_all) begin
            first_q <= 1'b1;
            after_q <= 1'b0;
            trap_pend_q <= 1'b0;
            trap_sel_q <= 2'b00;
        end else begin
            after_q <= (state_q == S_JUMP) && (kind_q != EK_RESET);
            if (state_q == S_RUN && INSN_DONE_I) begin
                first_q <= 1'b0;
            end
            if (trap_take) begin
                trap_pend_q <= 1'b0;
            end else if (state_q == S_RUN && TRAP_I) begin
                trap_pend_q <= 1'b1;
                trap_sel_q <= TRAP_SEL_I;
            end
        end
    end

    // Status and handshake outputs
    always_ff @(posedge CLK_I) begin
        if (rst_all) begin
            CORE_HALT_O <= 1'b1;
            CHIP_RST_O <= 1'b1;
            IRQ_ACK_O <= 1'b0;
            ACK_VEC_O <= 6'h00;
            last_vec_q <= 6'h00;
        end else begin
            CHIP_RST_O <= 1'b0;
            CORE_HALT_O <= !(state_q == S_RUN && !int_take && !trap_take) && !(state_q == S_JUMP);
            IRQ_ACK_O <= int_take;
            if (int_take) begin
                ACK_VEC_O <= pick_vec;
            end
            if (state_q == S_JUMP) begin
                last_vec_q <= vec_q;
            end
        end
    end

endmodule : es_exception_sequencer

`default_nettype wire

// ---- logic/es_pkg.sv ----
// Package for the exception sequencer: bus map, field layout, vectors and types
package es_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] ES_OFS_CTRL = 8'h00;
    localparam logic [7:0] ES_OFS_PRIO = 8'h04;
    localparam logic [7:0] ES_OFS_STAT = 8'h08;

    // Control register fields and reset values
    localparam int ES_CTRL_ADV_BIT = 0;
    localparam int ES_CTRL_UBS_BIT = 1;
    localparam logic ES_ADV_RST = 1'b0;
    localparam logic ES_UBS_RST = 1'b1;
    localparam logic [7:0] ES_PRIO_RST = 8'h00;

    // Condition flags layout
    localparam int ES_CCR_MASK_BIT = 7;
    localparam int ES_CCR_AUX_BIT = 6;

    // Vector numbers
    localparam logic [5:0] ES_VEC_RESET = 6'h00;
    localparam logic [5:0] ES_VEC_NMI = 6'h07;
    localparam logic [5:0] ES_VEC_TRAP = 6'h08;
    localparam logic [5:0] ES_VEC_EXT = 6'h0C;
    localparam logic [5:0] ES_VEC_INT = 6'h14;
    localparam int ES_N_EXT = 6;
    localparam int ES_N_INT = 27;
    localparam int ES_N_VEC = 64;

    // Status register fields
    localparam int ES_ST_BUSY_BIT = 8;
    localparam int ES_ST_FIRST_BIT = 9;
    localparam int ES_ST_TRAP_BIT = 10;

    typedef enum logic [1:0] {
        EK_RESET,
        EK_IRQ,
        EK_TRAP
    } es_kind_e;

    typedef struct packed {
        logic req;
        logic [31:0] data;
    } es_push_s;

    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } es_fetch_s;

    typedef struct packed {
        logic adv_mode;
        logic user_bit_select;
        logic [7:0] priority_select_a;
        logic [7:0] priority_select_b;
    } es_ctrl_s;

endpackage : es_pkg

// ---- test/es_core_model.sv ----
// Core-side responder: acknowledges stack pushes and vector reads
`timescale 1ns/10ps
`default_nettype none
module es_core_model
    import es_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic slow_i, // late answers
    input wire es_push_s stk_i, // push
    input wire es_fetch_s vec_i, // read
    output logic stk_ack_o, // push done
    output logic vec_ack_o, // read done
    output logic [23:0] vec_data_o // vector word
);
    logic [2:0] s_cnt_q;
    logic [2:0] v_cnt_q;
    logic [2:0] lim;
    logic [23:0] rom;
    assign lim = slow_i ? 3'h5 : 3'h0;
    assign rom = {8'hA5, vec_i.addr ^ 16'h1234};
    // Word is valid only in the ack cycle, inverted otherwise
    assign vec_data_o = vec_ack_o ? rom : ~rom;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !stk_i.req || stk_ack_o) begin
            s_cnt_q <= 3'h0;
        end else if (s_cnt_q != lim) begin
            s_cnt_q <= s_cnt_q + 3'h1;
        end
        stk_ack_o <= rst_n_i && stk_i.req && !stk_ack_o && s_cnt_q == lim;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !vec_i.req || vec_ack_o) begin
            v_cnt_q <= 3'h0;
        end else if (v_cnt_q != lim) begin
            v_cnt_q <= v_cnt_q + 3'h1;
        end
        vec_ack_o <= rst_n_i && vec_i.req && !vec_ack_o && v_cnt_q == lim;
    end
endmodule : es_core_model
`default_nettype wire

// ---- test/es_exception_sequencer_tb_top.sv ----
// Self-checking bench for the exception sequencer
`timescale 1ns/10ps
`default_nettype none
module es_exception_sequencer_tb_top
    import es_pkg::*;
;
    localparam int TMO = 3000;
    logic clk, rst_n, wdt, hsel, hwrite, nmi, done, trap, slow;
    logic hrdy, hresp, stk_ack, vec_ack, ccr_wr, jump, halt, crst, iack;
    logic [1:0] htrans, tsel;
    logic [31:0] haddr, hwdata, hrdata, rd, sdat;
    logic [5:0] ext, avec;
    logic [26:0] intr;
    logic [23:0] pc, vdata, jpc, jpc_seen;
    logic [7:0] condition_flags_reg, ccr_o, ccr_seen;
    logic [15:0] vaddr;
    es_push_s stk;
    es_fetch_s vec;
    int n_errors, num_checks, njmp, nirq, nstk, cyc;
    logic [5:0] avq[$];
    es_exception_sequencer u_dut (.CLK_I(clk), .RST_N_I(rst_n), .WDT_OVF_I(wdt), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hrdy),
        .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .NMI_REQ_I(nmi),
        .EXT_REQ_I(ext), .INT_REQ_I(intr), .INSN_DONE_I(done), .TRAP_I(trap), .TRAP_SEL_I(tsel),
        .CORE_PC_I(pc), .CORE_CCR_I(condition_flags_reg), .STK_ACK_I(stk_ack), .VEC_ACK_I(vec_ack), .VEC_DATA_I(vdata),
        .STK_O(stk), .VEC_O(vec), .CCR_WR_O(ccr_wr), .CCR_O(ccr_o), .JUMP_O(jump), .JUMP_PC_O(jpc),
        .CORE_HALT_O(halt), .CHIP_RST_O(crst), .IRQ_ACK_O(iack), .ACK_VEC_O(avec));
    es_core_model u_core (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .stk_i(stk), .vec_i(vec),
        .stk_ack_o(stk_ack), .vec_ack_o(vec_ack), .vec_data_o(vdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Records the sequence outputs; a source drops its request once accepted
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if ($rose(stk.req)) nstk <= nstk + 1;
        if ($rose(stk.req)) sdat <= stk.data;
        if (vec.req) vaddr <= vec.addr;
        if (ccr_wr) ccr_seen <= ccr_o;
        if (jump) jpc_seen <= jpc;
        if (jump) njmp <= njmp + 1;
        if (iack) begin
            nirq <= nirq + 1;
            avq.push_back(avec);
            if (avec == 6'h07) nmi <= 1'b0;
            else if (avec < 6'h12) ext[avec - 6'h0C] <= 1'b0;
            else intr[avec - 6'h14] <= 1'b0;
        end
    end
    function automatic logic [23:0] xpc(input logic adv, input logic [15:0] a);
        return {adv ? 8'hA5 : 8'h00, a ^ 16'h1234};
    endfunction : xpc
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hrdy !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        // A slave that never answers counts as a mismatch
        if (hrdy !== 1'b1) n_errors++;
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic wait_j(input int k);
        int t0;
        int n;
        t0 = njmp;
        n = 0;
        while (njmp < t0 + k && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("jumps", njmp - t0, k);
    endtask : wait_j
    task automatic pulse(input logic t, input logic [1:0] s);
        done <= 1'b1;
        trap <= t;
        tsel <= s;
        @(posedge clk);
        done <= 1'b0;
        trap <= 1'b0;
        @(posedge clk);
    endtask : pulse
    task automatic complete_run();
        $display("Checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    initial begin
        while (cyc < TMO) @(posedge clk);
        n_errors++;
        complete_run();
    end
    initial begin
        {rst_n, wdt, hwrite, nmi, done, trap, slow, htrans, tsel} = '0;
        {haddr, hwdata, ext, intr} = '0;
        hsel = 1'b1;
        pc = 24'h0123A6;
        condition_flags_reg = 8'h80;
        repeat (2) @(posedge clk);
        chk("rst", {30'h0, crst, halt}, 32'h3);
        rst_n <= 1'b1;
        wait_j(1);
        chk("rvad", 32'(vaddr), 32'h0);
        chk("rjpc", 32'(jpc_seen), 32'(xpc(1'b0, 16'h0)));
        chk("rstk", nstk, 0);
        chk("rmsk", 32'(ccr_seen[7]), 32'h1);
        bus(1'b0, ES_OFS_CTRL, 32'h0);
        chk("ctrl", rd, 32'h2);
        bus(1'b0, ES_OFS_STAT, 32'h0);
        chk("stat", rd, 32'h200);
        bus(1'b0, 8'h0C, 32'h0);
        chk("umap", {rd[31:1], hresp}, 32'h0);
        bus(1'b1, ES_OFS_PRIO, 32'h8000);
        bus(1'b0, ES_OFS_PRIO, 32'h0);
        chk("prio", rd, 32'h8000);
        nmi <= 1'b1;
        repeat (8) @(posedge clk);
        chk("blk", nirq, 0);
        pulse(1'b0, 2'h0);
        @(posedge clk);
        chk("blk1", nirq, 0);
        pulse(1'b0, 2'h0);
        wait_j(1);
        chk("nmi", 32'(avq.pop_front()), 32'h7);
        chk("nvad", 32'(vaddr), 32'h0E);
        chk("nstk", sdat, {8'h80, 24'h0123A6});
        chk("nmsk", 32'(ccr_seen[7]), 32'h1);
        chk("njpc", 32'(jpc_seen), 32'(xpc(1'b0, 16'h0E)));
        bus(1'b0, ES_OFS_STAT, 32'h0);
        chk("nsta", rd, 32'h007);
        slow <= 1'b1;
        ext <= 6'h03;
        intr <= 27'h1;
        pulse(1'b0, 2'h0);
        repeat (4) @(posedge clk);
        chk("mask", nirq, 1);
        condition_flags_reg <= 8'h00;
        repeat (6) @(posedge clk);
        chk("idle", nirq, 1);
        pulse(1'b0, 2'h0);
        wait_j(3);
        chk("lvl", 32'(avq.pop_front()), 32'h14);
        chk("ord0", 32'(avq.pop_front()), 32'h0C);
        chk("ord1", 32'(avq.pop_front()), 32'h0D);
        slow <= 1'b0;
        condition_flags_reg <= 8'h80;
        bus(1'b1, ES_OFS_CTRL, 32'h1);
        for (int s = 0; s < 4; s++) begin
            pulse(1'b1, 2'(s));
            wait_j(1);
            chk("tvad", 32'(vaddr), 32'((8 + s) * 4));
            chk("tccr", 32'(ccr_seen[7:6]), 32'h3);
            chk("tjpc", 32'(jpc_seen), 32'(xpc(1'b1, 16'((8 + s) * 4))));
        end
        // Main mask set, aux clear, aux used as mask: level 1 passes, level 0 waits
        intr <= 27'h1;
        ext <= 6'h01;
        pulse(1'b0, 2'h0);
        wait_j(1);
        repeat (3) @(posedge clk);
        chk("ulvl", 32'(avq.pop_front()), 32'h14);
        chk("ublk", avq.size(), 0);
        bus(1'b1, ES_OFS_CTRL, 32'h3);
        pulse(1'b1, 2'h0);
        wait_j(1);
        chk("uccr", 32'(ccr_seen[7:6]), 32'h2);
        condition_flags_reg <= 8'h00;
        ext <= 6'h04;
        pulse(1'b1, 2'h1);
        wait_j(1);
        chk("rank", 32'(avq.pop_front()), 32'h0E);
        chk("ivad", 32'(vaddr), 32'h38);
        wait_j(1);
        chk("trap", 32'(vaddr), 32'h24);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        chk("mrst", {30'h0, crst, halt}, 32'h3);
        rst_n <= 1'b1;
        wait_j(1);
        bus(1'b0, ES_OFS_CTRL, 32'h0);
        chk("mctl", rd, 32'h2);
        bus(1'b1, ES_OFS_CTRL, 32'h1);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        wait_j(1);
        chk("wvad", 32'(vaddr), 32'h0);
        chk("wjpc", 32'(jpc_seen), 32'(xpc(1'b0, 16'h0)));
        complete_run();
    end
endmodule : es_exception_sequencer_tb_top
`default_nettype wire

// ---- test/es_seq_checker.sv ----
// Port-level checks for the exception sequencer
`timescale 1ns/10ps
`default_nettype none
module es_seq_checker
    import es_pkg::*;
(
    input wire logic CLK_I, // clock
    input wire logic RST_N_I, // reset
    input wire logic WDT_OVF_I, // watchdog
    input wire logic NMI_REQ_I, // nmi
    input wire logic INSN_DONE_I, // done
    input wire logic [23:0] CORE_PC_I, // pc
    input wire logic [7:0] CORE_CCR_I, // flags
    input wire logic STK_ACK_I, // push ack
    input wire logic VEC_ACK_I, // read ack
    input wire logic [23:0] VEC_DATA_I, // vector
    input wire es_push_s STK_O, // push
    input wire es_fetch_s VEC_O, // read
    input wire logic CCR_WR_O, // flags load
    input wire logic [7:0] CCR_O, // flags
    input wire logic JUMP_O, // jump
    input wire logic [23:0] JUMP_PC_O, // target
    input wire logic CORE_HALT_O, // stall
    input wire logic CHIP_RST_O, // init
    input wire logic IRQ_ACK_O, // accept
    input wire logic [5:0] ACK_VEC_O // vector
);
    logic blk_q;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Set by any reset, cleared when the first instruction completes
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || WDT_OVF_I) begin
            blk_q <= 1'b1;
        end else if (INSN_DONE_I) begin
            blk_q <= 1'b0;
        end
    end
    sequence s_fetch0;
        CCR_WR_O && CCR_O[ES_CCR_MASK_BIT] && VEC_O.req && VEC_O.addr == 16'h0000;
    endsequence
    sequence s_stk_done;
        STK_O.req && STK_ACK_I;
    endsequence
    sequence s_vec_done;
        VEC_O.req && VEC_ACK_I;
    endsequence
    AST_RST_OUT: assert property ($rose(RST_N_I) |-> CHIP_RST_O && CORE_HALT_O)
        else $error("outputs not in reset state at release");
    AST_RST_FETCH: assert property ($rose(RST_N_I) |-> !STK_O.req throughout (##[1:4] s_fetch0))
        else $error("reset entry sequence wrong");
    AST_WDT: assert property (WDT_OVF_I |=> CHIP_RST_O ##[1:5] s_fetch0)
        else $error("watchdog did not reset");
    AST_MASK_STEP: assert property (s_stk_done |=> !STK_O.req ##1 (CCR_WR_O && CCR_O[7] && VEC_O.req))
        else $error("mask not set after stacking");
    AST_STK_SRC: assert property ($rose(STK_O.req) |-> $past(INSN_DONE_I) || $past(JUMP_O) || $past(JUMP_O, 2))
        else $error("exception taken mid instruction");
    AST_STK_DATA: assert property ($rose(STK_O.req) |-> STK_O.data == {$past(CORE_CCR_I), $past(CORE_PC_I)})
        else $error("stacked word wrong");
    AST_JUMP: assert property (s_vec_done |=> !VEC_O.req ##1
        (JUMP_O && JUMP_PC_O[15:0] == $past(VEC_DATA_I[15:0], 2)))
        else $error("jump target differs from vector");
    AST_ACK_SET: assert property (IRQ_ACK_O |-> ACK_VEC_O == 6'h07 || (ACK_VEC_O >= 6'h0C && ACK_VEC_O <= 6'h11)
        || (ACK_VEC_O >= 6'h14 && ACK_VEC_O <= 6'h2E))
        else $error("illegal accepted vector");
    AST_NMI_TOP: assert property (IRQ_ACK_O && $past(NMI_REQ_I) |-> ACK_VEC_O == 6'h07)
        else $error("nmi not taken first");
    AST_FIRST_BLOCK: assert property (blk_q |-> !IRQ_ACK_O)
        else $error("interrupt before first instruction");
    AST_HALT: assert property (STK_O.req || VEC_O.req |-> CORE_HALT_O)
        else $error("core not stalled during sequence");
endmodule : es_seq_checker
bind es_exception_sequencer es_seq_checker u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .WDT_OVF_I(WDT_OVF_I),
    .NMI_REQ_I(NMI_REQ_I), .INSN_DONE_I(INSN_DONE_I), .CORE_PC_I(CORE_PC_I), .CORE_CCR_I(CORE_CCR_I),
    .STK_ACK_I(STK_ACK_I), .VEC_ACK_I(VEC_ACK_I), .VEC_DATA_I(VEC_DATA_I), .STK_O(STK_O), .VEC_O(VEC_O),
    .CCR_WR_O(CCR_WR_O), .CCR_O(CCR_O), .JUMP_O(JUMP_O), .JUMP_PC_O(JUMP_PC_O), .CORE_HALT_O(CORE_HALT_O),
    .CHIP_RST_O(CHIP_RST_O), .IRQ_ACK_O(IRQ_ACK_O), .ACK_VEC_O(ACK_VEC_O));
`default_nettype wire
